// ---- hdl/cskr_pkg.sv ----
// constants of the cpu-side search key register group.
// assumes a 32-bit ahb-lite slave window with one halfword per word.
package cskr_pkg;

   // -------------------------------------------------------------------
   // register indices; byte address is four times the index
   // -------------------------------------------------------------------
   localparam logic [7:0] IDX_KEY_LO       = 8'h80;
   localparam logic [7:0] IDX_KEY_HI       = 8'h81;
   localparam logic [7:0] IDX_MASK_LO      = 8'h82;
   localparam logic [7:0] IDX_MASK_HI      = 8'h83;
   localparam logic [7:0] IDX_CTRL         = 8'h84;
   localparam logic [7:0] IDX_KEY_TWO_LO   = 8'h86;
   localparam logic [7:0] IDX_KEY_TWO_HI   = 8'h87;
   localparam logic [7:0] IDX_MASK_TWO_LO  = 8'h88;
   localparam logic [7:0] IDX_MASK_TWO_HI  = 8'h89;
   localparam logic [7:0] IDX_CTRL_TWO     = 8'h8a;
   localparam logic [7:0] IDX_CMD_STATUS   = 8'h8c;

   // -------------------------------------------------------------------
   // widths, field positions and reset values
   // -------------------------------------------------------------------
   localparam int         HALF_W           = 16;
   localparam int         CTRL_W           = 5;
   localparam int         SEG_W            = 3;
   localparam int         SEG_LSB          = 0;
   localparam int         HEAD_BIT         = 3;
   localparam int         USAGE_BIT        = 4;
   localparam logic [15:0] HALF_RESET      = 16'h0000;
   localparam logic [4:0]  CTRL_RESET      = 5'h00;
   localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

   // -------------------------------------------------------------------
   // ahb-lite codes
   // -------------------------------------------------------------------
   localparam logic        HRESP_OKAY      = 1'b0;
   localparam int          HTRANS_VALID_BIT = 1;

   // -------------------------------------------------------------------
   // command kinds, one-hot, as shown on op_kind and in the status word
   // -------------------------------------------------------------------
   localparam logic [7:0] KIND_LOOKUP_ONE    = 8'h01;
   localparam logic [7:0] KIND_LOOKUP_TWO    = 8'h02;
   localparam logic [7:0] KIND_ALL_ONE       = 8'h04;
   localparam logic [7:0] KIND_TOP_HIT_ONE   = 8'h08;
   localparam logic [7:0] KIND_TOP_EMPTY_ONE = 8'h10;
   localparam logic [7:0] KIND_ALL_TWO       = 8'h20;
   localparam logic [7:0] KIND_TOP_HIT_TWO   = 8'h40;
   localparam logic [7:0] KIND_TOP_EMPTY_TWO = 8'h80;
   localparam logic [7:0] KIND_NONE          = 8'h00;

   // -------------------------------------------------------------------
   // bus state
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WR   = 3'b010,
      ST_RD   = 3'b100
   } cskr_state_t;

endpackage

// ---- hdl/cskr_key_set.sv ----
// one family of search parameters: key, ignore mask and segment control.
// assumes write strobes come from the bus slave, one halfword at a time.
`timescale 1ns/1ps
module cskr_key_set
   import cskr_pkg::*;
#(
   parameter int HW = HALF_W
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic [1:0]        key_we,
   input  wire logic [1:0]        mask_we,
   input  wire logic              ctrl_we,
   input  wire logic [HW-1:0]     wdata,
   output logic      [2*HW-1:0]   key,
   output logic      [2*HW-1:0]   mask,
   output logic      [CTRL_W-1:0] ctrl
);

   // -------------------------------------------------------------------
   // halfword storage
   // -------------------------------------------------------------------
   // each half has its own strobe so the other half never moves
   genvar h;
   generate
      for (h = 0; h < 2; h++) begin : g_half
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               key[h*HW +: HW]  <= HALF_RESET[HW-1:0];
               mask[h*HW +: HW] <= HALF_RESET[HW-1:0];
            end else begin
               if (key_we[h]) begin
                  key[h*HW +: HW] <= wdata;
               end
               if (mask_we[h]) begin
                  mask[h*HW +: HW] <= wdata;
               end
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // segment control
   // -------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= CTRL_RESET;
      end else if (ctrl_we) begin
         ctrl <= wdata[CTRL_W-1:0];
      end
   end

endmodule

// ---- hdl/cskr_top.sv ----
// cpu-side search key register group with an ahb-lite register port.
// assumes a single ahb-lite master, word transfers only, and a search
// engine that takes one command pulse at a time from op_* outputs.
//
// Functional notes
// - key and mask words are kept as two halves, each at own address
// - first mask bit 1 drops that key bit from compare, 0 keeps it
// - first-family stamp commands take their masked bits from mask one
// - control bit 4 set means usage bits get set during the search
// - control bit 3: 0 chains with previous result, 1 starts fresh
// - control bits 2..0 give the segment the search compares against
// - second lookup command uses key two as its 32-bit key
// - second-family stamps write key two; all-two selects no segment, top-hit/top-empty into the selected one
// - mask two has mask one layout, used by family two commands
// - family-two top-hit/top-empty stamps take segment from control two
// - first lookup uses key one; family-one stamps write key one
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module cskr_top
   import cskr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic      [31:0]       hrdata,
   input  wire logic              lookup_cmd_one,
   input  wire logic              lookup_cmd_two,
   input  wire logic              write_key_all_cmd,
   input  wire logic              write_key_top_hit_cmd,
   input  wire logic              write_key_top_empty_cmd,
   input  wire logic              write_key_all_cmd_two,
   input  wire logic              write_key_top_hit_cmd_two,
   input  wire logic              write_key_top_empty_cmd_two,
   output logic                   op_valid,
   output logic      [7:0]        op_kind,
   output logic      [31:0]       op_key,
   output logic      [31:0]       op_ignore,
   output logic      [SEG_W-1:0]  op_segment,
   output logic                   op_seg_used,
   output logic                   op_usage_set,
   output logic                   op_head
);

   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   cskr_state_t             state;
   logic [7:0]              idx_q;
   logic                    addr_ok_q;
   logic                    take;
   logic                    addr_ok;
   logic [1:0]              key_we_one;
   logic [1:0]              mask_we_one;
   logic                    ctrl_we_one;
   logic [1:0]              key_we_two;
   logic [1:0]              mask_we_two;
   logic                    ctrl_we_two;
   logic [31:0]             key_one;
   logic [31:0]             mask_one;
   logic [CTRL_W-1:0]       ctrl_one;
   logic [31:0]             key_two;
   logic [31:0]             mask_two;
   logic [CTRL_W-1:0]       ctrl_two;
   logic [7:0]              last_kind;
   logic [7:0]              next_kind;
   logic [31:0]             next_rdata;
   logic                    wr_active;

   // -------------------------------------------------------------------
   // address phase
   // -------------------------------------------------------------------
   // only whole words at aligned addresses map; hsize is not checked
   // since the master issues word transfers only
   assign take = hsel && htrans[HTRANS_VALID_BIT] && hready;
   assign addr_ok = (haddr[1:0] == 2'b00) &&
                    (haddr[ADDR_W-1:10] == '0);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx_q     <= 8'h00;
         addr_ok_q <= 1'b0;
      end else if (take) begin
         idx_q     <= haddr[9:2];
         addr_ok_q <= addr_ok;
      end
   end

   // -------------------------------------------------------------------
   // bus state machine
   // -------------------------------------------------------------------
   // reads take one wait state so hrdata can come from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE, ST_WR: begin
               if (take && hwrite) begin
                  state <= ST_WR;
               end else if (take) begin
                  state <= ST_RD;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_RD: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
      end else begin
         hreadyout <= !(take && !hwrite);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= HRESP_OKAY;
      end else begin
         hresp <= HRESP_OKAY;
      end
   end

   // -------------------------------------------------------------------
   // write decode
   // -------------------------------------------------------------------
   // unmapped writes fall through every compare and are dropped
   assign wr_active = (state == ST_WR) && addr_ok_q;

   always_comb begin
      key_we_one  = 2'b00;
      mask_we_one = 2'b00;
      ctrl_we_one = 1'b0;
      key_we_two  = 2'b00;
      mask_we_two = 2'b00;
      ctrl_we_two = 1'b0;
      if (wr_active) begin
         case (idx_q)
            IDX_KEY_LO:      key_we_one[0]  = 1'b1;
            IDX_KEY_HI:      key_we_one[1]  = 1'b1;
            IDX_MASK_LO:     mask_we_one[0] = 1'b1;
            IDX_MASK_HI:     mask_we_one[1] = 1'b1;
            IDX_CTRL:        ctrl_we_one    = 1'b1;
            IDX_KEY_TWO_LO:  key_we_two[0]  = 1'b1;
            IDX_KEY_TWO_HI:  key_we_two[1]  = 1'b1;
            IDX_MASK_TWO_LO: mask_we_two[0] = 1'b1;
            IDX_MASK_TWO_HI: mask_we_two[1] = 1'b1;
            IDX_CTRL_TWO:    ctrl_we_two    = 1'b1;
            default: begin
               ctrl_we_one = 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // the two parameter sets
   // -------------------------------------------------------------------
   cskr_key_set #(
      .HW      (HALF_W)
   ) u_set_one (
      .hclk    (hclk),
      .hresetn (hresetn),
      .key_we  (key_we_one),
      .mask_we (mask_we_one),
      .ctrl_we (ctrl_we_one),
      .wdata   (hwdata[HALF_W-1:0]),
      .key     (key_one),
      .mask    (mask_one),
      .ctrl    (ctrl_one)
   );

   // same layout as set one
   cskr_key_set #(
      .HW      (HALF_W)
   ) u_set_two (
      .hclk    (hclk),
      .hresetn (hresetn),
      .key_we  (key_we_two),
      .mask_we (mask_we_two),
      .ctrl_we (ctrl_we_two),
      .wdata   (hwdata[HALF_W-1:0]),
      .key     (key_two),
      .mask    (mask_two),
      .ctrl    (ctrl_two)
   );

   // -------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------
   // halves sit in the low 16 bits; unmapped reads return zero
   always_comb begin
      next_rdata = WORD_ZERO;
      if (addr_ok_q) begin
         case (idx_q)
            IDX_KEY_LO:      next_rdata[15:0] = key_one[15:0];
            IDX_KEY_HI:      next_rdata[15:0] = key_one[31:16];
            IDX_MASK_LO:     next_rdata[15:0] = mask_one[15:0];
            IDX_MASK_HI:     next_rdata[15:0] = mask_one[31:16];
            IDX_CTRL:        next_rdata[CTRL_W-1:0] = ctrl_one;
            IDX_KEY_TWO_LO:  next_rdata[15:0] = key_two[15:0];
            IDX_KEY_TWO_HI:  next_rdata[15:0] = key_two[31:16];
            IDX_MASK_TWO_LO: next_rdata[15:0] = mask_two[15:0];
            IDX_MASK_TWO_HI: next_rdata[15:0] = mask_two[31:16];
            IDX_CTRL_TWO:    next_rdata[CTRL_W-1:0] = ctrl_two;
            IDX_CMD_STATUS:  next_rdata[7:0] = last_kind;
            default:         next_rdata = WORD_ZERO;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= WORD_ZERO;
      end else if (state == ST_RD) begin
         hrdata <= next_rdata;
      end
   end

   // -------------------------------------------------------------------
   // command selection
   // -------------------------------------------------------------------
   // one command per cycle; if several pulse together the lowest kind
   // bit wins and the others are lost, the engine issues them singly
   always_comb begin
      if (lookup_cmd_one) begin
         next_kind = KIND_LOOKUP_ONE;
      end else if (lookup_cmd_two) begin
         next_kind = KIND_LOOKUP_TWO;
      end else if (write_key_all_cmd) begin
         next_kind = KIND_ALL_ONE;
      end else if (write_key_top_hit_cmd) begin
         next_kind = KIND_TOP_HIT_ONE;
      end else if (write_key_top_empty_cmd) begin
         next_kind = KIND_TOP_EMPTY_ONE;
      end else if (write_key_all_cmd_two) begin
         next_kind = KIND_ALL_TWO;
      end else if (write_key_top_hit_cmd_two) begin
         next_kind = KIND_TOP_HIT_TWO;
      end else if (write_key_top_empty_cmd_two) begin
         next_kind = KIND_TOP_EMPTY_TWO;
      end else begin
         next_kind = KIND_NONE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_valid <= 1'b0;
         op_kind  <= KIND_NONE;
      end else begin
         op_valid <= (next_kind != KIND_NONE);
         op_kind  <= next_kind;
      end
   end

   // kept so software can see which command was last served
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_kind <= KIND_NONE;
      end else if (next_kind != KIND_NONE) begin
         last_kind <= next_kind;
      end
   end

   // -------------------------------------------------------------------
   // key and ignore mask for the engine
   // -------------------------------------------------------------------
   // op_ignore bit 1 removes the key bit from compare
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_key    <= WORD_ZERO;
         op_ignore <= WORD_ZERO;
      end else begin
         case (next_kind)
            KIND_LOOKUP_ONE: begin
               op_key    <= key_one;
               op_ignore <= mask_one;
            end
            KIND_ALL_ONE, KIND_TOP_HIT_ONE, KIND_TOP_EMPTY_ONE: begin
               op_key    <= key_one;
               op_ignore <= mask_one;
            end
            KIND_LOOKUP_TWO: begin
               op_key    <= key_two;
               op_ignore <= mask_two;
            end
            KIND_ALL_TWO, KIND_TOP_HIT_TWO, KIND_TOP_EMPTY_TWO: begin
               op_key    <= key_two;
               op_ignore <= mask_two;
            end
            default: begin
               op_key    <= op_key;
               op_ignore <= op_ignore;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // segment and search flags
   // -------------------------------------------------------------------
   // the segment field is trusted as written; out of range values are
   // passed on unchanged
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_segment   <= '0;
         op_seg_used  <= 1'b0;
         op_usage_set <= 1'b0;
         op_head      <= 1'b0;
      end else begin
         case (next_kind)
            KIND_LOOKUP_ONE: begin
               op_segment   <= ctrl_one[SEG_LSB +: SEG_W];
               op_seg_used  <= 1'b1;
               op_usage_set <= ctrl_one[USAGE_BIT];
               op_head      <= ctrl_one[HEAD_BIT];
            end
            KIND_LOOKUP_TWO: begin
               op_segment   <= ctrl_two[SEG_LSB +: SEG_W];
               op_seg_used  <= 1'b1;
               op_usage_set <= ctrl_two[USAGE_BIT];
               op_head      <= ctrl_two[HEAD_BIT];
            end
            KIND_TOP_HIT_TWO, KIND_TOP_EMPTY_TWO: begin
               op_segment   <= ctrl_two[SEG_LSB +: SEG_W];
               op_seg_used  <= 1'b1;
               op_usage_set <= 1'b0;
               op_head      <= 1'b0;
            end
            KIND_ALL_ONE, KIND_TOP_HIT_ONE, KIND_TOP_EMPTY_ONE,
            KIND_ALL_TWO: begin
               op_segment   <= '0;
               op_seg_used  <= 1'b0;
               op_usage_set <= 1'b0;
               op_head      <= 1'b0;
            end
            default: begin
               op_segment   <= op_segment;
               op_seg_used  <= op_seg_used;
               op_usage_set <= op_usage_set;
               op_head      <= op_head;
            end
         endcase
      end
   end

endmodule

// ---- verification/cskr_chk.sv ----
// port assertions for the search key register group.
// assumes one clock domain and hready tied to hreadyout.
`timescale 1ns/1ps
module cskr_chk
   import cskr_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [7:0]  cmd,
   input wire logic        op_valid,
   input wire logic [7:0]  op_kind,
   input wire logic [31:0] op_key,
   input wire logic [31:0] op_ignore,
   input wire logic [2:0]  op_segment,
   input wire logic        op_seg_used,
   input wire logic        op_usage_set,
   input wire logic        op_head
);
   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   logic       taken;
   logic [7:0] low_cmd;
   assign taken   = hsel && htrans[1] && hready;
   // lowest pin wins when several commands collide
   assign low_cmd = cmd & (~cmd + 8'h01);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   a_resp_okay: assert property (hresp == HRESP_OKAY)
      else $error("hresp not okay");
   a_write_no_wait: assert property (taken && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_read_one_wait: assert property (
      taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait not exactly one cycle");
   a_cmd_answer: assert property (
      (|cmd) |=> op_valid && $onehot(op_kind))
      else $error("command not answered next cycle");
   a_idle_quiet: assert property (
      !(|cmd) |=> !op_valid && op_kind == KIND_NONE)
      else $error("op pulse without command");
   a_lowest_wins: assert property (
      (|cmd) |=> op_kind == $past(low_cmd))
      else $error("wrong command kind served");
   a_stamp_one: assert property (
      (|cmd[4:2]) && !(|cmd[1:0]) |=> !op_seg_used && !op_usage_set
      && !op_head && op_segment == 3'h0)
      else $error("family one stamp carries segment fields");
   a_stamp_two_seg: assert property (
      (|cmd[7:6]) && !(|cmd[5:0]) |=> op_seg_used)
      else $error("family two stamp lost its segment");
   a_op_hold: assert property (
      !(|cmd) |=> $stable(op_key) && $stable(op_ignore)
      && $stable(op_segment))
      else $error("op values moved without command");

   c_read: cover property (taken && !hwrite);
   c_collide: cover property (cmd[0] && cmd[7]);
   c_empty_two: cover property (op_kind == KIND_TOP_EMPTY_TWO);
endmodule

bind cskr_top cskr_chk u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp),
   .cmd({write_key_top_empty_cmd_two, write_key_top_hit_cmd_two,
         write_key_all_cmd_two, write_key_top_empty_cmd,
         write_key_top_hit_cmd, write_key_all_cmd,
         lookup_cmd_two, lookup_cmd_one}),
   .op_valid(op_valid), .op_kind(op_kind), .op_key(op_key),
   .op_ignore(op_ignore), .op_segment(op_segment),
   .op_seg_used(op_seg_used), .op_usage_set(op_usage_set),
   .op_head(op_head)
);

// ---- verification/cskr_host.sv ----
// host processor model: single word transfers on the register port.
// assumes tasks are entered just after a rising edge.
`timescale 1ns/1ps
module cskr_host (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [11:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
   end

   // waits use the value settled at the falling edge, so the sample
   // never races the slave's own update at the rising edge
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output bit to);
      int n;
      logic r;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      n = 0;
      do begin
         @(negedge hclk);
         r = hready;
         @(posedge hclk);
         n++;
      end while (!r && n < 100);
      hsel <= 1'b0;
      htrans <= 2'b00;
      // an idle data bus never repeats the last value
      hwdata <= w ? d : ~hwdata;
      do begin
         @(negedge hclk);
         r = hready;
         q = hrdata;
         @(posedge hclk);
         n++;
      end while (!r && n < 200);
      to = (n >= 200);
   endtask
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the search key register group.
// assumes the host model drives the register port, the bench the commands.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
   import cskr_pkg::*;
   // segments per entry of the table behind the block
   localparam int SEGS = 8;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, op_key, op_ignore;
   logic [7:0]  cmd = 8'h00;
   logic [7:0]  op_kind;
   logic [2:0]  op_segment;
   logic        op_valid, op_seg_used, op_usage_set, op_head;
   logic [78:0] op_all;
   logic [15:0] sh [10];
   logic [7:0]  idx [10] = '{IDX_KEY_LO, IDX_KEY_HI, IDX_MASK_LO,
      IDX_MASK_HI, IDX_CTRL, IDX_KEY_TWO_LO, IDX_KEY_TWO_HI,
      IDX_MASK_TWO_LO, IDX_MASK_TWO_HI, IDX_CTRL_TWO};
   int          fails = 0;
   int          tests_run = 0;

   assign op_all = {op_valid, op_kind, op_key, op_ignore, op_segment,
                    op_seg_used, op_usage_set, op_head};
   always #20 hclk = ~hclk;

   cskr_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .lookup_cmd_one(cmd[0]),
      .lookup_cmd_two(cmd[1]), .write_key_all_cmd(cmd[2]),
      .write_key_top_hit_cmd(cmd[3]), .write_key_top_empty_cmd(cmd[4]),
      .write_key_all_cmd_two(cmd[5]), .write_key_top_hit_cmd_two(cmd[6]),
      .write_key_top_empty_cmd_two(cmd[7]), .op_valid(op_valid),
      .op_kind(op_kind), .op_key(op_key), .op_ignore(op_ignore),
      .op_segment(op_segment), .op_seg_used(op_seg_used),
      .op_usage_set(op_usage_set), .op_head(op_head));

   cskr_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));

   // -------------------------------------------------------------------
   // expectations
   // -------------------------------------------------------------------
   function automatic logic [31:0] rd_exp(input int i);
      if (i == 4 || i == 9) begin
         return {27'h000_0000, sh[i][4:0]};
      end
      return {16'h0000, sh[i]};
   endfunction

   function automatic logic [78:0] exp_op(input logic [7:0] v);
      logic [7:0]  kind;
      logic        two, lk, sg;
      logic [4:0]  c;
      kind = v & (~v + 8'h01);
      two = |(kind & 8'he2);
      lk = |(kind & 8'h03);
      sg = |(kind & 8'hc3);
      c = two ? sh[9][4:0] : sh[4][4:0];
      return {1'b1, kind, two ? {sh[6], sh[5]} : {sh[1], sh[0]},
              two ? {sh[8], sh[7]} : {sh[3], sh[2]},
              sg ? c[2:0] : 3'h0, sg, lk & c[4], lk & c[3]};
   endfunction

   // valid, kind, segment and the flag bits of a packed op word
   function automatic logic [14:0] ctl(input logic [78:0] x);
      return {x[78:70], x[5:0]};
   endfunction

   // -------------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------------
   task automatic end_sim();
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      bit to;
      host.xfer(w, a, d, q, to);
      if (to) begin
         fails++;
         end_sim();
      end
   endtask

   // every kind back to back, then a collision and a random mix
   task automatic run_cmds();
      logic [7:0]  seq [10];
      logic [78:0] e;
      logic [31:0] q;
      for (int k = 0; k < 8; k++) begin
         seq[k] = 8'h01 << k;
      end
      seq[8] = 8'ha4;
      seq[9] = 8'($urandom()) | 8'h80;
      cmd <= seq[0];
      for (int k = 0; k < 10; k++) begin
         @(posedge hclk);
         cmd <= (k < 9) ? seq[k + 1] : 8'h00;
         @(negedge hclk);
         e = exp_op(seq[k]);
         `CHK("op_data", e[69:6], op_all[69:6])
         `CHK("op_ctrl", ctl(e), ctl(op_all))
      end
      @(posedge hclk);
      // status word keeps the kind of the last command served
      bus(1'b0, 12'h230, 32'h0000_0000, q);
      `CHK("status", {24'h00_0000, e[77:70]}, q)
   endtask

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial begin
      logic [31:0] v, q;
      void'($urandom(32'h59c6));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < 10; i++) begin
            v = $urandom();
            // first round: halves of one word set to opposite extremes
            if (r == 0) begin
               v = (i % 2 == 1) ? 32'hffff_ffff : 32'h0000_0000;
            end
            if (i == 4 || i == 9) begin
               v[2:0] = 3'($urandom_range(SEGS - 1));
            end
            bus(1'b1, {2'b00, idx[i], 2'b00}, v, q);
            sh[i] = v[15:0];
         end
         // reverse order: first read hits the word just written
         for (int i = 9; i >= 0; i--) begin
            bus(1'b0, {2'b00, idx[i], 2'b00}, 32'h0000_0000, q);
            `CHK("reg", rd_exp(i), q)
         end
         bus(1'b1, 12'h214, 32'hffff_ffff, q);
         bus(1'b0, 12'h214, 32'h0000_0000, q);
         `CHK("unmapped", 32'h0000_0000, q)
         run_cmds();
      end
      end_sim();
   end
endmodule
